// *** verilog/bhb_pkg.sv ***
`default_nettype none
package bhb_pkg;
   // register word offsets, byte addresses on the plain port
   localparam logic [7:0] OFF_LAT_HDR = 8'h0C;
   localparam logic [7:0] OFF_BUS_NUM = 8'h18;
   localparam logic [7:0] OFF_IO_STS = 8'h1C;
   localparam logic [7:0] OFF_IRQ_STS = 8'h40;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h44;
   // hardwired field values
   localparam logic [7:0] LAT_TIMER_VAL = 8'h00;
   localparam logic [7:0] HDR_TYPE_VAL = 8'h01;
   localparam logic [3:0] IO_ADDR_CAP = 4'h1;
   // field positions
   localparam int HDR_TYPE_LSB = 16;
   localparam int UP_BUS_LSB = 0;
   localparam int DN_BUS_LSB = 8;
   localparam int HI_BUS_LSB = 16;
   localparam int IO_BASE_LSB = 4;
   localparam int IO_LIMIT_LSB = 12;
   // reset values
   localparam logic [7:0] BUS_NUM_RST = 8'h00;
   localparam logic [3:0] IO_WIN_RST = 4'h0;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   // fill of the low window address bits
   localparam logic [11:0] IO_BOTTOM_FILL = 12'h000;
   localparam logic [11:0] IO_TOP_FILL = 12'hFFF;
   // event indices, shared by status flags and interrupt bits
   localparam int NUM_EV = 6;
   localparam int EV_PAR = 0;
   localparam int EV_STA = 1;
   localparam int EV_RTA = 2;
   localparam int EV_RMA = 3;
   localparam int EV_SSE = 4;
   localparam int EV_DPE = 5;
   // word bit of each flag in the status half of offset 1ch
   localparam int SEC_POS [NUM_EV] = '{24, 27, 28, 29, 30, 31};
   // flags that software may clear; the others hold until reset
   localparam logic [NUM_EV-1:0] SEC_W1C_MASK = 6'h31;
   localparam logic [NUM_EV-1:0] FLAGS_RST = 6'h00;

   // sticky flag update, a set in the clearing cycle wins
   function automatic logic w1c_next(input logic cur,
                                      input logic set,
                                      input logic clr);
      w1c_next = set | (cur & ~clr);
   endfunction
endpackage
`default_nettype wire

// *** verilog/bhb_win_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// window bounds and one lookup between the bank and the decoder
interface bhb_win_if;
   logic [3:0] base_lo;
   logic [3:0] limit_lo;
   logic [15:0] base_hi;
   logic [15:0] limit_hi;
   logic req_valid;
   logic [31:0] req_addr;
   logic fwd_valid;
   logic fwd_hit;
   modport ctl (output base_lo, output limit_lo, output base_hi,
                output limit_hi, output req_valid, output req_addr,
                input fwd_valid, input fwd_hit);
   modport win (input base_lo, input limit_lo, input base_hi,
                input limit_hi, input req_valid, input req_addr,
                output fwd_valid, output fwd_hit);
endinterface
`default_nettype wire

// *** verilog/bhb_io_window.sv ***
`timescale 1ns/1ps
`default_nettype none
// registered i/o window lookup: one answer per request, next cycle
module bhb_io_window
   import bhb_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   bhb_win_if.win w
);
   logic [31:0] bottom; // lowest address inside the window
   logic [31:0] top; // highest address inside the window
   logic hit_nxt;

   // full 32-bit bounds from upper and lower halves
   assign bottom = {w.base_hi, w.base_lo, IO_BOTTOM_FILL};
   assign top = {w.limit_hi, w.limit_lo, IO_TOP_FILL};
   // base above limit gives an empty window, nothing forwarded
   assign hit_nxt = (w.req_addr >= bottom) && (w.req_addr <= top);

   // answer register, valid for one cycle
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         w.fwd_valid <= 1'b0;
         w.fwd_hit <= 1'b0;
      end
      else
      begin
         w.fwd_valid <= w.req_valid;
         w.fwd_hit <= w.req_valid & hit_nxt;
      end
   end

   property p_fwd_hit;
      @(posedge mclk) disable iff (sys_rst)
      w.req_valid |=> w.fwd_valid && (w.fwd_hit ==
         (($past(w.req_addr) >= {$past(w.base_hi), $past(w.base_lo),
            12'h000}) && ($past(w.req_addr) <= {$past(w.limit_hi),
            $past(w.limit_lo), 12'hFFF})));
   endproperty
   a_fwd_hit: assert property (p_fwd_hit)
      else $error("window decision wrong");

   property p_fwd_idle;
      @(posedge mclk) disable iff (sys_rst)
      !w.req_valid |=> !w.fwd_valid && !w.fwd_hit;
   endproperty
   a_fwd_idle: assert property (p_fwd_idle)
      else $error("answer without a request");

   c_fwd_hit: cover property (@(posedge mclk) disable iff (sys_rst)
      w.req_valid ##1 w.fwd_hit);
endmodule
`default_nettype wire

// *** verilog/bhb_regs.sv ***
// Function
// - both latency timer bytes read zero
// - header type byte reads 01h
// - upstream bus number, read-write, resets zero
// - downstream bus number, read-write, resets zero
// - highest bus number, read-write, resets zero
// - addressing nibbles read 1h, 32-bit i/o
// - i/o base nibble gives bottom bits 15:12
// - i/o limit nibble gives top bits 15:12
// - forward i/o inside the base/limit window
// - upper 16 bounds bits come from outside
// - legacy status fields always read zero
// - parity flag set only with parity response
// - completer abort sent sets its flag
// - completer abort received sets its flag
// - unsupported request received sets its flag
// - error message sent with serr sets flag
// - poisoned packet received sets its flag
`timescale 1ns/1ps
`default_nettype none
module bhb_regs
   import bhb_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   // plain register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // enables held in registers outside this bank
   input wire logic parity_resp_en,
   input wire logic serr_en,
   // upper halves of the i/o window bounds
   input wire logic [15:0] io_base_hi,
   input wire logic [15:0] io_limit_hi,
   // downstream-side events, one-cycle pulses
   input wire logic ev_parity_err,
   input wire logic ev_abort_sent,
   input wire logic ev_abort_rcvd,
   input wire logic ev_unsup_rcvd,
   input wire logic ev_err_msg_sent,
   input wire logic ev_poison_rcvd,
   // i/o forwarding lookup
   input wire logic io_req_valid,
   input wire logic [31:0] io_req_addr,
   output logic io_fwd_valid,
   output logic io_fwd_hit,
   // stored bus numbers for the routing logic
   output logic [7:0] upstream_bus,
   output logic [7:0] downstream_bus,
   output logic [7:0] highest_bus,
   // level interrupt
   output logic irq
);
   // bus number fields
   logic [7:0] up_bus_r;
   logic [7:0] dn_bus_r;
   logic [7:0] hi_bus_r;
   // writable nibbles of the i/o window
   logic [3:0] io_base_r;
   logic [3:0] io_limit_r;
   // secondary status flags, indexed by event
   logic [NUM_EV-1:0] sec_flag_r;
   // interrupt status and mask, same layout
   logic [NUM_EV-1:0] irq_sts_r;
   logic [NUM_EV-1:0] irq_mask_r;
   logic irq_r;
   // read data register and its next value
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   // qualified events and decoded writes
   logic [NUM_EV-1:0] ev_set;
   logic [NUM_EV-1:0] sec_clr;
   logic [NUM_EV-1:0] irq_clr;
   logic wr_bus;
   logic wr_io;
   logic wr_irq_sts;
   logic wr_irq_mask;
   logic [15:0] sec_status;

   bhb_win_if win_if ();

   // lookup engine, kept apart so it can be retimed alone
   bhb_io_window u_win (
      .mclk (mclk),
      .sys_rst (sys_rst),
      .w (win_if)
   );

   // window bounds and requests go straight to the lookup
   assign win_if.base_lo = io_base_r;
   assign win_if.limit_lo = io_limit_r;
   assign win_if.base_hi = io_base_hi;
   assign win_if.limit_hi = io_limit_hi;
   assign win_if.req_valid = io_req_valid;
   assign win_if.req_addr = io_req_addr;

   // write decode; offset 0ch holds nothing writable
   assign wr_bus = reg_wr && (reg_addr == OFF_BUS_NUM);
   assign wr_io = reg_wr && (reg_addr == OFF_IO_STS);
   assign wr_irq_sts = reg_wr && (reg_addr == OFF_IRQ_STS);
   assign wr_irq_mask = reg_wr && (reg_addr == OFF_IRQ_MASK);

   // event qualification
   always_comb
   begin
      ev_set = '0;
      // parity flag never sets while parity response is off
      ev_set[EV_PAR] = ev_parity_err & parity_resp_en;
      ev_set[EV_STA] = ev_abort_sent;
      ev_set[EV_RTA] = ev_abort_rcvd;
      ev_set[EV_RMA] = ev_unsup_rcvd;
      ev_set[EV_SSE] = ev_err_msg_sent & serr_en;
      ev_set[EV_DPE] = ev_poison_rcvd;
   end

   // clear vectors; read-only flags ignore written ones
   always_comb
   begin
      for (int i = 0; i < NUM_EV; i++)
      begin
         sec_clr[i] = wr_io && reg_wdata[SEC_POS[i]]
                      && SEC_W1C_MASK[i];
         irq_clr[i] = wr_irq_sts && reg_wdata[i];
      end
   end

   // bus number registers
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         up_bus_r <= BUS_NUM_RST;
         dn_bus_r <= BUS_NUM_RST;
         hi_bus_r <= BUS_NUM_RST;
      end
      else if (wr_bus)
      begin
         // the latency byte 31:24 is dropped here
         up_bus_r <= reg_wdata[UP_BUS_LSB +: 8];
         dn_bus_r <= reg_wdata[DN_BUS_LSB +: 8];
         hi_bus_r <= reg_wdata[HI_BUS_LSB +: 8];
      end
   end

   // i/o window nibbles; capability nibbles are not stored
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         io_base_r <= IO_WIN_RST;
         io_limit_r <= IO_WIN_RST;
      end
      else if (wr_io)
      begin
         io_base_r <= reg_wdata[IO_BASE_LSB +: 4];
         io_limit_r <= reg_wdata[IO_LIMIT_LSB +: 4];
      end
   end

   // secondary status flags, sticky until cleared or reset
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         sec_flag_r <= FLAGS_RST;
      end
      else
      begin
         for (int i = 0; i < NUM_EV; i++)
         begin
            // a set in the clearing cycle is kept
            sec_flag_r[i] <= w1c_next(sec_flag_r[i], ev_set[i],
                                      sec_clr[i]);
         end
      end
   end

   // interrupt status, fed by the same qualified events
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         irq_sts_r <= FLAGS_RST;
      end
      else
      begin
         for (int i = 0; i < NUM_EV; i++)
         begin
            irq_sts_r[i] <= w1c_next(irq_sts_r[i], ev_set[i],
                                     irq_clr[i]);
         end
      end
   end

   // interrupt mask, all sources off after reset
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         irq_mask_r <= FLAGS_RST;
      end
      else if (wr_irq_mask)
      begin
         irq_mask_r <= reg_wdata[NUM_EV-1:0];
      end
   end

   // interrupt output registered; one cycle behind the status
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         irq_r <= 1'b0;
      end
      else
      begin
         irq_r <= |(irq_sts_r & irq_mask_r);
      end
   end

   // status half: legacy and reserved bits stay zero
   always_comb
   begin
      sec_status = 16'h0000;
      for (int i = 0; i < NUM_EV; i++)
      begin
         sec_status[SEC_POS[i] - 16] = sec_flag_r[i];
      end
   end

   // read mux; unmapped offsets read as zero
   always_comb
   begin
      rdata_nxt = RDATA_RST;
      case (reg_addr)
         OFF_LAT_HDR:
         begin
            rdata_nxt[HDR_TYPE_LSB +: 8] = HDR_TYPE_VAL;
            rdata_nxt[15:8] = LAT_TIMER_VAL;
         end
         OFF_BUS_NUM:
         begin
            rdata_nxt[UP_BUS_LSB +: 8] = up_bus_r;
            rdata_nxt[DN_BUS_LSB +: 8] = dn_bus_r;
            rdata_nxt[HI_BUS_LSB +: 8] = hi_bus_r;
            rdata_nxt[31:24] = LAT_TIMER_VAL;
         end
         OFF_IO_STS:
         begin
            rdata_nxt[3:0] = IO_ADDR_CAP;
            rdata_nxt[IO_BASE_LSB +: 4] = io_base_r;
            rdata_nxt[11:8] = IO_ADDR_CAP;
            rdata_nxt[IO_LIMIT_LSB +: 4] = io_limit_r;
            rdata_nxt[31:16] = sec_status;
         end
         OFF_IRQ_STS:
         begin
            rdata_nxt[NUM_EV-1:0] = irq_sts_r;
         end
         OFF_IRQ_MASK:
         begin
            rdata_nxt[NUM_EV-1:0] = irq_mask_r;
         end
         default:
         begin
            rdata_nxt = RDATA_RST;
         end
      endcase
   end

   // read data stand for one cycle only, zero otherwise
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         rdata_r <= RDATA_RST;
      end
      else
      begin
         rdata_r <= reg_rd ? rdata_nxt : RDATA_RST;
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata = rdata_r;
   assign upstream_bus = up_bus_r;
   assign downstream_bus = dn_bus_r;
   assign highest_bus = hi_bus_r;
   assign io_fwd_valid = win_if.fwd_valid;
   assign io_fwd_hit = win_if.fwd_hit;
   assign irq = irq_r;

   // checks
   property p_hdr_read;
      @(posedge mclk) disable iff (sys_rst)
      reg_rd && (reg_addr == OFF_LAT_HDR) |=>
         reg_rdata == 32'h0001_0000;
   endproperty
   a_hdr_read: assert property (p_hdr_read)
      else $error("header word wrong");

   property p_bus_write;
      @(posedge mclk) disable iff (sys_rst)
      wr_bus |=> upstream_bus == $past(reg_wdata[7:0])
         && downstream_bus == $past(reg_wdata[15:8])
         && highest_bus == $past(reg_wdata[23:16]);
   endproperty
   a_bus_write: assert property (p_bus_write)
      else $error("bus numbers not stored");

   property p_bus_read;
      @(posedge mclk) disable iff (sys_rst)
      reg_rd && (reg_addr == OFF_BUS_NUM) |=> reg_rdata ==
         {8'h00, $past(hi_bus_r), $past(dn_bus_r), $past(up_bus_r)};
   endproperty
   a_bus_read: assert property (p_bus_read)
      else $error("bus word read wrong");

   property p_io_read;
      @(posedge mclk) disable iff (sys_rst)
      reg_rd && (reg_addr == OFF_IO_STS) |=>
         reg_rdata[3:0] == 4'h1 && reg_rdata[11:8] == 4'h1
         && reg_rdata[23:16] == 8'h00 && reg_rdata[26:25] == 2'h0;
   endproperty
   a_io_read: assert property (p_io_read)
      else $error("i/o status constants wrong");

   property p_io_write;
      @(posedge mclk) disable iff (sys_rst)
      wr_io |=> io_base_r == $past(reg_wdata[7:4])
         && io_limit_r == $past(reg_wdata[15:12]);
   endproperty
   a_io_write: assert property (p_io_write)
      else $error("window nibbles not stored");

   property p_par_gate;
      @(posedge mclk) disable iff (sys_rst)
      !sec_flag_r[EV_PAR] && !(ev_parity_err && parity_resp_en)
         |=> !sec_flag_r[EV_PAR];
   endproperty
   a_par_gate: assert property (p_par_gate)
      else $error("parity flag set while gated");

   property p_abort_set;
      @(posedge mclk) disable iff (sys_rst)
      ev_abort_sent || ev_abort_rcvd || ev_unsup_rcvd |=>
         (sec_flag_r[EV_STA] || !$past(ev_abort_sent))
         && (sec_flag_r[EV_RTA] || !$past(ev_abort_rcvd))
         && (sec_flag_r[EV_RMA] || !$past(ev_unsup_rcvd));
   endproperty
   a_abort_set: assert property (p_abort_set)
      else $error("abort flag not set");

   property p_ro_hold;
      @(posedge mclk) disable iff (sys_rst)
      sec_flag_r[EV_STA] ##1 !sys_rst |-> sec_flag_r[EV_STA];
   endproperty
   a_ro_hold: assert property (p_ro_hold)
      else $error("read-only flag cleared");

   property p_sse_set;
      @(posedge mclk) disable iff (sys_rst)
      ev_err_msg_sent && serr_en |=> sec_flag_r[EV_SSE];
   endproperty
   a_sse_set: assert property (p_sse_set)
      else $error("system error flag not set");

   property p_dpe_clear;
      @(posedge mclk) disable iff (sys_rst)
      wr_io && reg_wdata[31] && !ev_poison_rcvd |=>
         !sec_flag_r[EV_DPE] ##1 !sec_flag_r[EV_DPE] || $past(
         ev_poison_rcvd);
   endproperty
   a_dpe_clear: assert property (p_dpe_clear)
      else $error("poison flag not cleared");

   property p_dpe_set;
      @(posedge mclk) disable iff (sys_rst)
      ev_poison_rcvd |=> sec_flag_r[EV_DPE] && irq_sts_r[EV_DPE];
   endproperty
   a_dpe_set: assert property (p_dpe_set)
      else $error("poison set lost");

   property p_irq_raise;
      @(posedge mclk) disable iff (sys_rst)
      ev_poison_rcvd && irq_mask_r[EV_DPE] && !wr_irq_mask
         |-> ##[1:2] irq;
   endproperty
   a_irq_raise: assert property (p_irq_raise)
      else $error("interrupt not raised");

   c_clear_race: cover property (@(posedge mclk) disable iff (sys_rst)
      wr_io && reg_wdata[31] && ev_poison_rcvd);
   c_irq: cover property (@(posedge mclk) disable iff (sys_rst)
      !irq ##1 irq);
   c_bus_rd: cover property (@(posedge mclk) disable iff (sys_rst)
      wr_bus ##1 reg_rd && reg_addr == OFF_BUS_NUM);
endmodule
`default_nettype wire

// *** verification/bhb_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// configuration requester on the plain register port
module bhb_host_model
(
   input wire logic mclk,
   output logic [7:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [31:0] reg_rdata
);
   // idle port at time zero, no strobe until the bench asks
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // one write, entered just after a rising edge; returns at the
   // sampling edge so a read may follow with no gap
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      // released data lines must not look like the last word
      reg_wdata <= ~d;
   endtask

   // one read; data stand only in the cycle after the read edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      d = reg_rdata;
      @(posedge mclk);
   endtask
endmodule
`default_nettype wire

// *** verification/bridge_header_bus_io_status_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// self-checking bench: design against a behavioural model
module bridge_header_bus_io_status_regs_test
   import bhb_pkg::*;
();
   logic mclk;
   logic sys_rst;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic parity_resp_en;
   logic serr_en;
   logic [15:0] io_base_hi;
   logic [15:0] io_limit_hi;
   logic [5:0] ev; // event pulses, in event-index order
   logic io_req_valid;
   logic [31:0] io_req_addr;
   logic io_fwd_valid;
   logic io_fwd_hit;
   logic [7:0] upstream_bus;
   logic [7:0] downstream_bus;
   logic [7:0] highest_bus;
   logic irq;
   int n_fail = 0;
   int tests_run = 0;
   integer seed = 32'h877c_4393;
   // model state
   logic [23:0] m_bus;
   logic [3:0] m_base;
   logic [3:0] m_lim;
   logic [5:0] m_sec; // sticky flags, event order
   logic [5:0] m_ists;
   logic [5:0] m_mask;
   logic [1:0] q_fwd [$]; // pending lookup answers: valid, hit
   logic [31:0] rdat;
   // mid-cycle snapshots, away from the edge that updates them
   logic irq_s;
   logic [23:0] bus_s;
   logic [1:0] fwd_s;
   logic [7:0] addrs [8] = '{8'h0C, 8'h18, 8'h1C, 8'h40, 8'h44,
                             8'h10, 8'h19, 8'h48};

   bhb_regs uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .parity_resp_en(parity_resp_en),
      .serr_en(serr_en), .io_base_hi(io_base_hi),
      .io_limit_hi(io_limit_hi), .ev_parity_err(ev[EV_PAR]),
      .ev_abort_sent(ev[EV_STA]), .ev_abort_rcvd(ev[EV_RTA]),
      .ev_unsup_rcvd(ev[EV_RMA]), .ev_err_msg_sent(ev[EV_SSE]),
      .ev_poison_rcvd(ev[EV_DPE]), .io_req_valid(io_req_valid),
      .io_req_addr(io_req_addr), .io_fwd_valid(io_fwd_valid),
      .io_fwd_hit(io_fwd_hit), .upstream_bus(upstream_bus),
      .downstream_bus(downstream_bus), .highest_bus(highest_bus),
      .irq(irq));

   bhb_host_model host (.mclk(mclk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));

   // 40 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // snapshot outputs at the falling edge
   always @(negedge mclk)
   begin
      irq_s <= irq;
      bus_s <= {highest_bus, downstream_bus, upstream_bus};
      fwd_s <= {io_fwd_valid, io_fwd_hit};
   end

   function automatic logic [31:0] rnd();
      rnd = $random(seed);
   endfunction

   // expected word at a byte address; unmapped reads give zero
   function automatic logic [31:0] exp_word(input logic [7:0] a);
      case (a)
         8'h0C: exp_word = 32'h0001_0000;
         8'h18: exp_word = {8'h00, m_bus};
         8'h1C: exp_word = {m_sec[5:1], 2'h0, m_sec[0], 8'h00,
                            m_lim, 4'h1, m_base, 4'h1};
         OFF_IRQ_STS: exp_word = {26'h000_0000, m_ists};
         OFF_IRQ_MASK: exp_word = {26'h000_0000, m_mask};
         default: exp_word = 32'h0000_0000;
      endcase
   endfunction

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // read one word and compare it, the interrupt and the bus numbers
   task automatic rchk(input logic [7:0] a);
      host.rd(a, rdat);
      chk("rdata", exp_word(a), rdat);
      chk("irq", {31'h0, |(m_ists & m_mask)}, {31'h0, irq_s});
      chk("bus", {8'h00, m_bus}, {8'h00, bus_s});
   endtask

   // raise events; the model sets only qualified flags
   task automatic fire(input logic [5:0] which);
      ev <= which;
      for (int i = 0; i < 6; i++)
         if (which[i] && (i != EV_PAR || parity_resp_en) &&
             (i != EV_SSE || serr_en))
         begin
            m_sec[i] = 1'b1;
            m_ists[i] = 1'b1;
         end
   endtask

   task automatic pulse(input logic [5:0] which);
      fire(which);
      @(posedge mclk);
      ev <= 6'h00;
   endtask

   // write with model update; events in the same cycle set after clear
   task automatic wr_m(input logic [7:0] a, input logic [31:0] d,
                       input logic [5:0] which);
      if (a == 8'h18)
         m_bus = d[23:0];
      if (a == 8'h1C)
      begin
         m_base = d[7:4];
         m_lim = d[15:12];
         m_sec = m_sec & ~{d[31], d[30], 3'h0, d[24]};
      end
      if (a == OFF_IRQ_STS)
         m_ists = m_ists & ~d[5:0];
      if (a == OFF_IRQ_MASK)
         m_mask = d[5:0];
      fire(which);
      host.wr(a, d);
      ev <= 6'h00;
   endtask

   // back-to-back and gapped lookups at the window edges
   task automatic lookups(input int n);
      logic [31:0] lo;
      logic [31:0] hi;
      logic [31:0] a;
      logic v;
      logic [1:0] e;
      lo = {io_base_hi, m_base, 12'h000};
      hi = {io_limit_hi, m_lim, 12'hFFF};
      for (int j = 0; j <= n; j++)
      begin
         case (j % 5)
            0: a = lo;
            1: a = hi;
            2: a = lo - 32'h0000_0001;
            3: a = hi + 32'h0000_0001;
            default: a = rnd();
         endcase
         v = (j < n) && (j % 7 != 3);
         io_req_valid <= v;
         io_req_addr <= a;
         q_fwd.push_back({v, v && a >= lo && a <= hi});
         @(posedge mclk);
         if (q_fwd.size() > 1)
         begin
            e = q_fwd.pop_front();
            chk("fwd", {30'h0, e}, {30'h0, fwd_s});
         end
      end
      q_fwd.delete();
   endtask

   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      m_bus = 24'h00_0000;
      m_base = 4'h0;
      m_lim = 4'h0;
      m_sec = 6'h00;
      m_ists = 6'h00;
      m_mask = 6'h00;
      @(posedge mclk);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // main sequence
   initial
   begin
      ev = 6'h00;
      parity_resp_en = 1'b0;
      serr_en = 1'b0;
      io_base_hi = 16'h0000;
      io_limit_hi = 16'h0000;
      io_req_valid = 1'b0;
      io_req_addr = 32'h0000_0000;
      do_reset();
      for (int k = 0; k < 8; k++)
         rchk(addrs[k]);
      // every event with its enable off and on
      for (int k = 0; k < 12; k++)
      begin
         parity_resp_en <= k[0];
         serr_en <= k[0];
         wr_m(8'h1C, 32'hFFFF_0000, 6'h00);
         rchk(8'h1C);
         pulse(6'h01 << (k / 2));
         rchk(8'h1C);
      end
      // set beats clear in the same cycle
      wr_m(8'h1C, 32'hFFFF_0000, 6'h3F);
      rchk(8'h1C);
      wr_m(OFF_IRQ_MASK, 32'h0000_003F, 6'h00);
      rchk(OFF_IRQ_STS);
      wr_m(OFF_IRQ_STS, 32'h0000_003F, 6'h00);
      rchk(OFF_IRQ_STS);
      // random rounds over registers, events and lookups
      for (int k = 0; k < 16; k++)
      begin
         parity_resp_en <= 1'(rnd());
         serr_en <= 1'(rnd());
         io_base_hi <= 16'(rnd());
         io_limit_hi <= 16'(rnd());
         wr_m(8'h18, rnd(), 6'h00);
         rchk(8'h18);
         wr_m(8'h0C, rnd(), 6'h00);
         rchk(8'h0C);
         wr_m(8'h48, rnd(), 6'h00);
         rchk(8'h48);
         wr_m(8'h1C, rnd(), 6'(rnd()));
         rchk(8'h1C);
         wr_m(OFF_IRQ_MASK, rnd(), 6'(rnd()));
         rchk(OFF_IRQ_STS);
         pulse(6'(rnd()));
         rchk(8'h1C);
         wr_m(OFF_IRQ_STS, rnd(), 6'h00);
         rchk(OFF_IRQ_STS);
         lookups(12);
      end
      // second reset after the random rounds returns every stored field and flag to zero
      do_reset();
      for (int k = 0; k < 8; k++)
         rchk(addrs[k]);
      final_report();
   end

   // cut a hang short
   initial
   begin
      #(25 * 20000);
      n_fail++;
      final_report();
   end
endmodule
`default_nettype wire
